/* File: rtl/spc_pkg.sv */
// Purpose: Constants for the sync output and power control block.
// Assumes: Eight-bit register addresses and eight-bit register data.
// Notes: Register offsets, field positions and reset values live here only.
package spc_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_POWER = 8'h00;
   localparam logic [7:0] REG_INPUT_MODE = 8'h01;
   localparam logic [7:0] REG_SYNC_OUT = 8'h02;
   localparam logic [7:0] REG_DAC_LOW_POWER = 8'h0D;
   localparam logic [7:0] REG_CABLE = 8'h10;
   localparam logic [7:0] REG_READBACK_A = 8'h13;
   localparam logic [7:0] REG_READBACK_B = 8'h14;
   localparam logic [7:0] REG_READBACK_C = 8'h16;
   localparam logic [7:0] REG_SOFT_RESET = 8'h17;
   localparam logic [7:0] REG_HD_SYNC_FMT = 8'h30;
   localparam logic [7:0] REG_HD_SYNC_CTL = 8'h34;
   localparam logic [7:0] REG_TELETEXT = 8'hC9;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int POWER_SLEEP_BIT = 0;
   localparam int POWER_DAC_LSB = 2;
   localparam int INPUT_MODE_LSB = 4;
   localparam int INPUT_MODE_MSB = 6;
   localparam logic [2:0] INPUT_MODE_SD = 3'h0;
   localparam int SYNC_SD_EN_BIT = 6;
   localparam int SYNC_HD_EN_BIT = 7;
   localparam int LOW_POWER_LSB = 0;
   localparam int CABLE_DAC1_BIT = 0;
   localparam int CABLE_DAC2_BIT = 1;
   localparam int CABLE_DET_EN_BIT = 3;
   localparam int CABLE_AUTO_PD_BIT = 4;
   localparam int CABLE_COMPONENT_BIT = 5;
   localparam logic [7:0] CABLE_WR_MASK = 8'h38;
   localparam int SOFT_RESET_BIT = 1;
   localparam int HD_FMT_EMBEDDED_BIT = 2;
   localparam int HD_HSYNC_CTL_BIT = 1;
   localparam int HD_VSYNC_CTL_BIT = 2;
   localparam int TELETEXT_EN_BIT = 0;
   localparam int RDBK_HSYNC_BIT = 0;
   localparam int RDBK_VSYNC_BIT = 1;
   localparam int RDBK_SFL_BIT = 2;

   // ----------------------------------------------------------------
   // Reset values and widths
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [2:0] DAC3_RST = 3'h0;
   localparam logic [1:0] CABLE_STAT_RST = 2'h3;
   localparam int PIXEL_W = 16;
   localparam int PIN_W = 19;

   // ----------------------------------------------------------------
   // Sync pin source selection
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      SRC_TRI = 5'h01,
      SRC_SD = 5'h02,
      SRC_EXT = 5'h04,
      SRC_TRS = 5'h08,
      SRC_CNT = 5'h10
   } spc_sync_src_e;

endpackage

/* File: rtl/spc_pin_sync.sv */
// Purpose: Three-stage synchroniser for pins from outside the clock domain.
// Assumes: A level counts once the second and third stages agree.
// Notes: The first stage is read by the second stage only.
`timescale 1ns/100ps
module spc_pin_sync
#(
   parameter int WIDTH = 19
)
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [WIDTH-1:0] pins_in,
   output logic [WIDTH-1:0] level_out
);

   // ----------------------------------------------------------------
   // Per-bit synchroniser
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++)
      begin : g_bit
         logic s1_ff;
         logic s2_ff;
         logic s3_ff;
         logic lvl_ff;
         wire agree = (s2_ff == s3_ff);
         always_ff @(posedge clk_in)
         begin
            if (rst_in)
            begin
               s1_ff <= 1'b0;
               s2_ff <= 1'b0;
               s3_ff <= 1'b0;
               lvl_ff <= 1'b0;
            end
            else
            begin
               s1_ff <= pins_in[gi];
               s2_ff <= s1_ff;
               s3_ff <= s2_ff;
               if (agree)
               begin
                  lvl_ff <= s3_ff;
               end
            end
         end
         assign level_out[gi] = lvl_ff;
      end
   endgenerate

endmodule // spc_pin_sync

/* File: rtl/spc_sync_power_ctrl.sv */
// Purpose: Sync pin output selection, DAC power control, cable status,
//          sleep, pin readback, software reset and teletext enable.
// Assumes: Simple register port fed by the serial host front end.
// Notes: Timing sources arrive aligned to the output video.
`timescale 1ns/100ps
module spc_sync_power_ctrl
   import spc_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [PIXEL_W-1:0] pixel_pins_in,
   input wire logic hsync_pin_in,
   input wire logic vsync_pin_in,
   input wire logic subcarrier_lock_pin_in,
   input wire logic sd_hsync_in,
   input wire logic sd_vsync_in,
   input wire logic trs_h_in,
   input wire logic trs_v_in,
   input wire logic trs_f_in,
   input wire logic cnt_hsync_in,
   input wire logic cnt_vsync_serr_in,
   input wire logic cnt_vsync_vbi_in,
   input wire logic std_interlaced_in,
   input wire logic std_525p_in,
   input wire logic std_pal_in,
   input wire logic frame_start_in,
   input wire logic [1:0] cable_sense_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_rvalid_out,
   output logic hsync_out,
   output logic hsync_oe_out,
   output logic vsync_out,
   output logic vsync_oe_out,
   output logic [2:0] dac_power_out,
   output logic [2:0] dac_low_power_out,
   output logic sleep_out,
   output logic teletext_enable_out
);

   // ----------------------------------------------------------------
   // Registers and pin synchronisers
   // ----------------------------------------------------------------
   logic [7:0] power_ff;
   logic [7:0] input_mode_ff;
   logic [7:0] sync_out_ff;
   logic [2:0] lowpwr_ff;
   logic [7:0] cable_ctl_ff;
   logic [1:0] cable_stat_ff;
   logic [2:0] pd_ff;
   logic [7:0] hd_fmt_ff;
   logic [7:0] hd_ctl_ff;
   logic [7:0] ttx_ff;
   logic [PIN_W-1:0] rdbk_ff;
   logic soft_rst_ff;
   logic [PIN_W-1:0] pin_lvl;
   spc_sync_src_e h_src;
   spc_sync_src_e v_src;
   logic nxt_hsync;
   logic nxt_vsync;

   spc_pin_sync #(.WIDTH(PIN_W)) u_pin_sync
   (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .pins_in({subcarrier_lock_pin_in, vsync_pin_in, hsync_pin_in, pixel_pins_in}),
      .level_out(pin_lvl)
   );

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire any_rst = rst_in | soft_rst_ff;
   wire sleep = power_ff[POWER_SLEEP_BIT];
   wire [2:0] dac_on = power_ff[POWER_DAC_LSB +: 3];
   wire sd_en = sync_out_ff[SYNC_SD_EN_BIT];
   wire hd_en = sync_out_ff[SYNC_HD_EN_BIT];
   wire embedded = hd_fmt_ff[HD_FMT_EMBEDDED_BIT];
   wire h_ctl = hd_ctl_ff[HD_HSYNC_CTL_BIT];
   wire v_ctl = hd_ctl_ff[HD_VSYNC_CTL_BIT];
   wire det_en = cable_ctl_ff[CABLE_DET_EN_BIT];
   wire auto_pd = cable_ctl_ff[CABLE_AUTO_PD_BIT] & det_en;
   wire component = cable_ctl_ff[CABLE_COMPONENT_BIT];
   wire det_tick = frame_start_in & det_en & ~sleep;
   wire mon1 = dac_on[0];
   wire mon2 = dac_on[1] & ~component;
   wire miss1 = ~cable_sense_in[0];
   wire miss2 = ~cable_sense_in[1];
   wire rdbk_en = ~sleep &
      (input_mode_ff[INPUT_MODE_MSB:INPUT_MODE_LSB] == INPUT_MODE_SD);
   wire wr_power = reg_wr_in & (reg_addr_in == REG_POWER);
   wire wr_mode = reg_wr_in & (reg_addr_in == REG_INPUT_MODE);
   wire wr_sync = reg_wr_in & (reg_addr_in == REG_SYNC_OUT);
   wire wr_lowpwr = reg_wr_in & (reg_addr_in == REG_DAC_LOW_POWER);
   wire wr_cable = reg_wr_in & (reg_addr_in == REG_CABLE);
   wire wr_fmt = reg_wr_in & (reg_addr_in == REG_HD_SYNC_FMT);
   wire wr_ctl = reg_wr_in & (reg_addr_in == REG_HD_SYNC_CTL);
   wire wr_ttx = reg_wr_in & (reg_addr_in == REG_TELETEXT);
   wire wr_soft = reg_wr_in & (reg_addr_in == REG_SOFT_RESET) &
      reg_wdata_in[SOFT_RESET_BIT];
   wire [7:0] cable_rd = (cable_ctl_ff & CABLE_WR_MASK) | {6'h00, cable_stat_ff};
   wire [2:0] nxt_pd = component ? {miss1, miss1, miss1} :
      {miss2 & mon2, miss2 & mon2, miss1 & mon1};
   wire [7:0] rd_data =
      (reg_addr_in == REG_POWER) ? power_ff :
      (reg_addr_in == REG_INPUT_MODE) ? input_mode_ff :
      (reg_addr_in == REG_SYNC_OUT) ? sync_out_ff :
      (reg_addr_in == REG_DAC_LOW_POWER) ? {5'h00, lowpwr_ff} :
      (reg_addr_in == REG_CABLE) ? cable_rd :
      (reg_addr_in == REG_READBACK_A) ? rdbk_ff[7:0] :
      (reg_addr_in == REG_READBACK_B) ? rdbk_ff[15:8] :
      (reg_addr_in == REG_READBACK_C) ? {5'h00, rdbk_ff[18:16]} :
      (reg_addr_in == REG_SOFT_RESET) ? {6'h00, soft_rst_ff, 1'b0} :
      (reg_addr_in == REG_HD_SYNC_FMT) ? hd_fmt_ff :
      (reg_addr_in == REG_HD_SYNC_CTL) ? hd_ctl_ff :
      (reg_addr_in == REG_TELETEXT) ? ttx_ff : REG_RST;

   // ----------------------------------------------------------------
   // Sync source selection
   // ----------------------------------------------------------------
   assign h_src = sleep ? SRC_TRI :
      hd_en ? (h_ctl ? SRC_CNT : (embedded ? SRC_TRS : SRC_EXT)) :
      sd_en ? SRC_SD : SRC_TRI;
   assign v_src = sleep ? SRC_TRI :
      hd_en ? (v_ctl ? SRC_CNT : (embedded ? SRC_TRS : SRC_EXT)) :
      sd_en ? SRC_SD : SRC_TRI;

   always_comb
   begin
      nxt_hsync = 1'b1;
      nxt_vsync = 1'b1;
      unique case (h_src)
         SRC_TRI: nxt_hsync = 1'b1;
         SRC_SD: nxt_hsync = sd_hsync_in;
         SRC_EXT: nxt_hsync = pin_lvl[PIXEL_W + RDBK_HSYNC_BIT];
         SRC_TRS: nxt_hsync = trs_h_in;
         SRC_CNT: nxt_hsync = cnt_hsync_in;
      endcase
      unique case (v_src)
         SRC_TRI: nxt_vsync = 1'b1;
         SRC_SD: nxt_vsync = sd_vsync_in;
         SRC_EXT: nxt_vsync = pin_lvl[PIXEL_W + RDBK_VSYNC_BIT];
         SRC_TRS: nxt_vsync = std_interlaced_in ? trs_f_in : trs_v_in;
         SRC_CNT: nxt_vsync = std_525p_in ? cnt_vsync_vbi_in : cnt_vsync_serr_in;
      endcase
   end

   // One output stage for every source keeps pulse starts aligned.
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         hsync_out <= 1'b1;
         vsync_out <= 1'b1;
         hsync_oe_out <= 1'b0;
         vsync_oe_out <= 1'b0;
      end
      else
      begin
         hsync_out <= nxt_hsync;
         vsync_out <= nxt_vsync;
         hsync_oe_out <= (h_src != SRC_TRI);
         vsync_oe_out <= (v_src != SRC_TRI);
      end
   end

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         soft_rst_ff <= 1'b0;
      end
      else
      begin
         soft_rst_ff <= wr_soft & ~soft_rst_ff;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (any_rst)
      begin
         power_ff <= REG_RST;
         input_mode_ff <= REG_RST;
         sync_out_ff <= REG_RST;
         lowpwr_ff <= DAC3_RST;
         cable_ctl_ff <= REG_RST;
         hd_fmt_ff <= REG_RST;
         hd_ctl_ff <= REG_RST;
         ttx_ff <= REG_RST;
      end
      else
      begin
         if (wr_power) power_ff <= reg_wdata_in;
         if (wr_mode) input_mode_ff <= reg_wdata_in;
         if (wr_sync) sync_out_ff <= reg_wdata_in;
         if (wr_lowpwr) lowpwr_ff <= reg_wdata_in[LOW_POWER_LSB +: 3];
         if (wr_cable) cable_ctl_ff <= reg_wdata_in & CABLE_WR_MASK;
         if (wr_fmt) hd_fmt_ff <= reg_wdata_in;
         if (wr_ctl) hd_ctl_ff <= reg_wdata_in;
         if (wr_ttx) ttx_ff <= reg_wdata_in;
      end
   end

   // ----------------------------------------------------------------
   // Cable detection, auto power-down and readback
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (any_rst)
      begin
         cable_stat_ff <= CABLE_STAT_RST;
         pd_ff <= DAC3_RST;
         rdbk_ff <= '0;
      end
      else
      begin
         if (det_tick & mon1) cable_stat_ff[CABLE_DAC1_BIT] <= miss1;
         if (det_tick & mon2) cable_stat_ff[CABLE_DAC2_BIT] <= miss2;
         if (det_tick) pd_ff <= nxt_pd;
         if (rdbk_en) rdbk_ff <= pin_lvl;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         reg_rdata_out <= REG_RST;
         reg_rvalid_out <= 1'b0;
         dac_power_out <= DAC3_RST;
         dac_low_power_out <= DAC3_RST;
         sleep_out <= 1'b0;
         teletext_enable_out <= 1'b0;
      end
      else
      begin
         reg_rdata_out <= reg_rd_in ? rd_data : REG_RST;
         reg_rvalid_out <= reg_rd_in;
         dac_power_out <= dac_on & ~(pd_ff & {3{auto_pd}}) & {3{~sleep}};
         dac_low_power_out <= lowpwr_ff;
         sleep_out <= sleep;
         teletext_enable_out <= ttx_ff[TELETEXT_EN_BIT] & std_pal_in;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   sequence s_soft_wr;
      wr_soft && !soft_rst_ff;
   endsequence
   sequence s_soft_done;
      soft_rst_ff ##1 (!soft_rst_ff && lowpwr_ff == DAC3_RST && sync_out_ff == REG_RST);
   endsequence

   chk_both_off_tri: assert property (!sd_en && !hd_en |=> !hsync_oe_out && !vsync_oe_out)
      else $error("sync pins driven with both enables clear");
   chk_sd_sync_path: assert property (sd_en && !hd_en && !sleep |=>
      hsync_oe_out && hsync_out == $past(sd_hsync_in) && vsync_out == $past(sd_vsync_in))
      else $error("SD sync not on pins");
   chk_ext_hsync_copy: assert property (hd_en && !embedded && !h_ctl && !sleep |=>
      hsync_out == $past(pin_lvl[PIXEL_W + RDBK_HSYNC_BIT]))
      else $error("external hsync not copied");
   chk_trs_hsync_h: assert property (hd_en && embedded && !h_ctl && !sleep |=>
      hsync_out == $past(trs_h_in))
      else $error("hsync not following H bit");
   chk_cnt_hsync_src: assert property (hd_en && h_ctl && !sleep |=>
      hsync_oe_out && hsync_out == $past(cnt_hsync_in))
      else $error("hsync not from counter");
   chk_trs_vsync_fv: assert property (hd_en && embedded && !v_ctl && !sleep |=>
      vsync_out == ($past(std_interlaced_in) ? $past(trs_f_in) : $past(trs_v_in)))
      else $error("vsync not following F or V bit");
   chk_cnt_vsync_525: assert property (hd_en && v_ctl && !sleep && std_525p_in |=>
      vsync_out == $past(cnt_vsync_vbi_in))
      else $error("525p counter vsync wrong");
   chk_sleep_tri_out: assert property (sleep |=> !hsync_oe_out && !vsync_oe_out
      && dac_power_out == DAC3_RST)
      else $error("outputs active in sleep");
   chk_soft_self_clr: assert property (s_soft_wr |=> s_soft_done)
      else $error("software reset did not act or clear");
   chk_cable_stat_upd: assert property (det_tick && mon1 && !soft_rst_ff |=>
      cable_stat_ff[CABLE_DAC1_BIT] == !$past(cable_sense_in[0]))
      else $error("DAC 1 cable status not updated");
   chk_pd_frame_hold: assert property (!frame_start_in && !soft_rst_ff |=> $stable(pd_ff))
      else $error("power-down changed inside frame");
   chk_low_power_bits: assert property (!soft_rst_ff |=> dac_low_power_out == $past(lowpwr_ff))
      else $error("low power enables not driven");

endmodule // spc_sync_power_ctrl

/* File: verification/spc_video_src.sv */
// Purpose: Upstream video source model for the sync output and power control block.
// Assumes: The bench hands over one random word each clock.
// Notes: Pins change every 16 cycles; one frame pulse every FRAME_LEN cycles.
`timescale 1ns/100ps
module spc_video_src
#(
   parameter int FRAME_LEN = 64
)
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [31:0] rnd_in,
   output logic [7:0] timing_out = 8'h00,
   output logic [18:0] pins_out = 19'h00000,
   output logic frame_out = 1'b0
);
   logic [7:0] cnt_ff = 8'h00;
   always @(posedge clk_in)
   begin
      cnt_ff <= (rst_in || cnt_ff == 8'(FRAME_LEN - 1)) ? 8'h00 : cnt_ff + 8'h01;
      timing_out <= rnd_in[7:0];
      frame_out <= !rst_in && cnt_ff == 8'(FRAME_LEN - 1);
      if (cnt_ff[3:0] == 4'h0)
      begin
         pins_out <= rnd_in[26:8];
      end
   end
endmodule // spc_video_src

/* File: verification/test_sync_out_and_power_control.sv */
// Purpose: Self-checking bench for the sync output and power control block.
// Assumes: Writes land one cycle after the strobe, outputs one cycle later.
// Notes: Timing levels are random each cycle from an xorshift source.
`timescale 1ns/100ps
module test_sync_out_and_power_control;
   import spc_pkg::*;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [1:0] sense = 2'h3;
   logic [2:0] std = 3'h0;
   logic [31:0] rnd = 32'hCD9C;
   logic [7:0] tim, tim_q, rdata, got;
   logic [18:0] pins, pins_q, snap;
   logic frame, rvalid, hs, hs_oe, vs, vs_oe, sleep, ttx;
   logic [2:0] pwr, lowp;
   logic [1:0] stat = 2'h3;
   logic [1:0] v;
   int failures = 0;
   int n_tests = 0;
   int pin_age = 0;
   logic [7:0] regs [10] = '{REG_POWER, REG_INPUT_MODE, REG_SYNC_OUT, REG_DAC_LOW_POWER,
      REG_CABLE, REG_SOFT_RESET, REG_HD_SYNC_FMT, REG_HD_SYNC_CTL, REG_TELETEXT, 8'h55};
   logic [31:0] mt [8] = '{32'h40000000, 32'h00000000, 32'h80000000, 32'h80040001,
      32'h80040000, 32'h80040600, 32'h80000602, 32'hC0040000};

   spc_video_src #(.FRAME_LEN(64)) i_spc_video_src (.clk_in(clk_in), .rst_in(rst_in),
      .rnd_in(rnd), .timing_out(tim), .pins_out(pins), .frame_out(frame));
   spc_sync_power_ctrl i_spc_sync_power_ctrl (.clk_in(clk_in), .rst_in(rst_in),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .pixel_pins_in(pins[15:0]), .hsync_pin_in(pins[16]), .vsync_pin_in(pins[17]),
      .subcarrier_lock_pin_in(pins[18]), .sd_hsync_in(tim[0]), .sd_vsync_in(tim[1]),
      .trs_h_in(tim[2]), .trs_v_in(tim[3]), .trs_f_in(tim[4]), .cnt_hsync_in(tim[5]),
      .cnt_vsync_serr_in(tim[6]), .cnt_vsync_vbi_in(tim[7]), .std_interlaced_in(std[0]),
      .std_525p_in(std[1]), .std_pal_in(std[2]), .frame_start_in(frame),
      .cable_sense_in(sense), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
      .hsync_out(hs), .hsync_oe_out(hs_oe), .vsync_out(vs), .vsync_oe_out(vs_oe),
      .dac_power_out(pwr), .dac_low_power_out(lowp), .sleep_out(sleep),
      .teletext_enable_out(ttx));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // Returns {hsync enable, hsync, vsync enable, vsync} from last cycle's sources.
   function automatic logic [3:0] exp_sync(input logic [7:0] r02, r30, r34, input logic slp);
      logic h;
      logic vv;
      if (slp || r02[7:6] == 2'b00)
         return 4'b0101;
      if (!r02[SYNC_HD_EN_BIT])
         return {1'b1, tim_q[0], 1'b1, tim_q[1]};
      h = r34[HD_HSYNC_CTL_BIT] ? tim_q[5] : r30[HD_FMT_EMBEDDED_BIT] ? tim_q[2] : pins_q[16];
      if (r34[HD_VSYNC_CTL_BIT])
         vv = std[1] ? tim_q[7] : tim_q[6];
      else if (r30[HD_FMT_EMBEDDED_BIT])
         vv = std[0] ? tim_q[4] : tim_q[3];
      else
         vv = pins_q[17];
      return {1'b1, h, 1'b1, vv};
   endfunction

   function automatic logic [2:0] exp_pwr(input logic comp, input logic [1:0] s);
      if (comp)
         return s[0] ? 3'b111 : 3'b000;
      return {s[1], s[1], s[0]};
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      n_tests++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      @(negedge clk_in);
      check({7'h00, rvalid}, 8'h01, "read valid");
      check(rdata, e, "read data");
   endtask

   task automatic defaults();
      foreach (regs[i])
         rd_reg(regs[i], regs[i] == REG_CABLE ? 8'h03 : 8'h00);
   endtask

   task automatic wait_frame();
      int k;
      k = 0;
      do
      begin
         @(posedge clk_in);
         k++;
      end
      while (frame !== 1'b1 && k < 200);
      check({7'h00, frame}, 8'h01, "frame pulse");
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
   endtask

   task automatic sync_scan(input logic [7:0] r02, r30, r34, input logic slp);
      logic ext;
      ext = r02[7] && !r30[HD_FMT_EMBEDDED_BIT] && r34[2:1] != 2'b11 && !slp;
      repeat (40)
      begin
         @(negedge clk_in);
         if (pin_age > 8 || !ext)
            check({4'h0, hs_oe, hs, vs_oe, vs}, {4'h0, exp_sync(r02, r30, r34, slp)}, "sync");
      end
   endtask

   task automatic end_test(input string name);
      $display("end of %s", name);
   endtask

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      forever #5 clk_in = ~clk_in;
   end

   always @(posedge clk_in)
   begin
      rnd <= xs(rnd);
      tim_q <= tim;
      pins_q <= pins;
      pin_age <= (pins == pins_q) ? pin_age + 1 : 0;
   end

   initial
   begin
      repeat (20000) @(posedge clk_in);
      failures++;
      $display("unexpected at %0t: watchdog expired", $time);
      finish_test();
   end

   initial
   begin
      for (int r = 0; r < 2; r++)
      begin
         @(posedge clk_in);
         rst_in <= 1'b1;
         repeat (10) @(posedge clk_in);
         @(negedge clk_in);
         check({hs_oe, vs_oe, hs, vs, sleep, ttx, 2'b00}, 8'h30, "reset pins");
         check({2'b00, pwr, lowp}, 8'h00, "reset power");
         @(posedge clk_in);
         rst_in <= 1'b0;
         defaults();
         end_test("reset");
         if (r == 0)
         begin
            for (int m = 0; m < 8; m++)
            begin
               wr_reg(REG_SYNC_OUT, mt[m][31:24]);
               wr_reg(REG_HD_SYNC_FMT, mt[m][23:16]);
               wr_reg(REG_HD_SYNC_CTL, mt[m][15:8]);
               std <= mt[m][2:0];
               repeat (3) @(posedge clk_in);
               sync_scan(mt[m][31:24], mt[m][23:16], mt[m][15:8], 1'b0);
            end
            end_test("sync selection");
            repeat (4)
            begin
               got = rnd[7:0];
               wr_reg(REG_DAC_LOW_POWER, got);
               rd_reg(REG_DAC_LOW_POWER, {5'h00, got[2:0]});
               check({5'h00, lowp}, {5'h00, got[2:0]}, "low power");
            end
            wr_reg(REG_TELETEXT, 8'h01);
            for (int p = 0; p < 2; p++)
            begin
               @(posedge clk_in);
               std <= {p[0], 2'b00};
               repeat (3) @(posedge clk_in);
               @(negedge clk_in);
               check({7'h00, ttx}, {7'h00, p[0]}, "teletext");
            end
            end_test("low power and teletext");
            wr_reg(REG_INPUT_MODE, 8'h00);
            repeat (2)
            begin
               for (int k = 0; k < 40 && pin_age != 1; k++)
                  @(posedge clk_in);
               check({7'h00, pin_age == 1}, 8'h01, "pin change seen");
               snap = pins;
               wr_reg(REG_READBACK_A, ~snap[7:0]);
               repeat (4) @(posedge clk_in);
               rd_reg(REG_READBACK_A, snap[7:0]);
               rd_reg(REG_READBACK_B, snap[15:8]);
               rd_reg(REG_READBACK_C, {5'h00, snap[18:16]});
            end
            end_test("readback");
            wr_reg(REG_POWER, 8'h1C);
            for (int c = 0; c < 2; c++)
            begin
               wr_reg(REG_CABLE, c ? 8'hFF : 8'h18);
               for (int s = 0; s < 4; s++)
               begin
                  @(posedge clk_in);
                  v = 2'(s) ^ rnd[1:0];
                  sense <= v;
                  wait_frame();
                  stat = c ? {stat[1], ~v[0]} : ~v;
                  check({5'h00, pwr}, {5'h00, exp_pwr(c[0], v)}, "auto power");
                  @(posedge clk_in);
                  sense <= ~v;
                  repeat (8) @(posedge clk_in);
                  @(negedge clk_in);
                  check({5'h00, pwr}, {5'h00, exp_pwr(c[0], v)}, "held power");
                  rd_reg(REG_CABLE, {2'b00, c[0], 2'b11, 1'b0, stat});
               end
            end
            wr_reg(REG_CABLE, 8'h10);
            sense <= 2'b00;
            wait_frame();
            check({5'h00, pwr}, 8'h07, "auto power without detection");
            end_test("cable detection");
            wr_reg(REG_CABLE, 8'h18);
            sense <= 2'b11;
            wait_frame();
            wr_reg(REG_SYNC_OUT, 8'h40);
            wr_reg(REG_POWER, 8'h1D);
            sense <= 2'b00;
            repeat (2) @(posedge clk_in);
            sync_scan(8'h40, 8'h00, 8'h00, 1'b1);
            check({7'h00, sleep}, 8'h01, "sleep flag");
            wait_frame();
            rd_reg(REG_CABLE, 8'h18);
            wr_reg(REG_POWER, 8'h1C);
            end_test("sleep");
            wr_reg(REG_DAC_LOW_POWER, 8'h07);
            wr_reg(REG_SOFT_RESET, 8'h02);
            repeat (3) @(posedge clk_in);
            @(negedge clk_in);
            check({5'h00, lowp}, 8'h00, "soft reset low power");
            defaults();
            end_test("software reset");
            wr_reg(REG_TELETEXT, 8'h01);
         end
      end
      finish_test();
   end
endmodule // test_sync_out_and_power_control
